/* common/ctc_defines.svh */
// Constants for the Type 1 configuration decode and conversion block
`ifndef CTC_DEFINES_SVH
`define CTC_DEFINES_SVH

// Bus commands for configuration cycles
`define CTC_CMD_CFG_RD  4'hA
`define CTC_CMD_CFG_WR  4'hB

// Low address bit codes
`define CTC_AD_TYPE1    2'h1
`define CTC_AD_TYPE0    2'h0

// Express address field positions
`define CTC_X_BUS_MSB   31
`define CTC_X_BUS_LSB   24
`define CTC_X_DEV_MSB   23
`define CTC_X_DEV_LSB   19
`define CTC_X_FN_MSB    18
`define CTC_X_FN_LSB    16
`define CTC_X_EXT_MSB   11
`define CTC_X_EXT_LSB   8

// Parallel bus Type 1 address field positions
`define CTC_P_BUS_MSB   23
`define CTC_P_BUS_LSB   16
`define CTC_P_DEV_MSB   15
`define CTC_P_DEV_LSB   11
`define CTC_P_FN_MSB    10
`define CTC_P_FN_LSB    8

// Shared register number field
`define CTC_REG_MSB     7
`define CTC_REG_LSB     2

// Reset values and fill patterns
`define CTC_ALL_ONES    32'hFFFF_FFFF
`define CTC_RST_WORD    32'h0000_0000

`endif

/* common/ctc_pkg.sv */
// Types for the Type 1 configuration decode and conversion block
package ctc_pkg;

	// Answer status returned to the primary requester
	typedef enum logic [1:0] {
		CTC_STS_SC      = 2'h0,
		CTC_STS_UR      = 2'h1,
		CTC_STS_NOCLAIM = 2'h2,
		CTC_STS_TA      = 2'h3
	} ctc_sts_t;

	// Routing decision for one request
	typedef enum logic [1:0] {
		CTC_K_T0  = 2'h0,
		CTC_K_T1  = 2'h1,
		CTC_K_BAD = 2'h2
	} ctc_kind_t;

	// Request sequencer, Gray along idle, issue, wait
	typedef enum logic [1:0] {
		CTC_ST_IDLE  = 2'h0,
		CTC_ST_ISSUE = 2'h1,
		CTC_ST_WAIT  = 2'h3
	} ctc_state_t;

endpackage : ctc_pkg

/* verilog/ctc_route.sv */
// Field extraction and routing decision for a primary Type 1 request
`timescale 1ns/1ps
`default_nettype none
`include "ctc_defines.svh"

module ctc_route
	import ctc_pkg::*;
(
	input  wire logic        reverse,
	input  wire logic [3:0]  cmd,
	input  wire logic [31:0] addr,
	input  wire logic [7:0]  sec_bus,
	input  wire logic [7:0]  sub_bus,
	output ctc_kind_t        kind,
	output logic [7:0]       f_bus,
	output logic [4:0]       f_dev,
	output logic [2:0]       f_fn,
	output logic [5:0]       f_reg,
	output logic             accept,
	output ctc_sts_t         rej_sts,
	output logic             rej_ma,
	output logic             rej_invalid
);

	// Bus range test shared by both directions
	function automatic ctc_kind_t classify(input logic [7:0] bus,
		input logic [7:0] sec, input logic [7:0] sub);
		if (bus == sec) begin
			classify = CTC_K_T0; // [RULE2]
		end else if ((bus > sec) && (bus <= sub)) begin
			classify = CTC_K_T1; // [RULE3]
		end else begin
			classify = CTC_K_BAD; // [RULE4]
		end
	endfunction : classify

	logic [3:0] f_ext;
	logic       fmt_ok;

	// Field positions differ by primary side
	always_comb begin
		f_reg = addr[`CTC_REG_MSB:`CTC_REG_LSB];
		if (reverse) begin
			f_bus = addr[`CTC_P_BUS_MSB:`CTC_P_BUS_LSB];
			f_dev = addr[`CTC_P_DEV_MSB:`CTC_P_DEV_LSB];
			f_fn  = addr[`CTC_P_FN_MSB:`CTC_P_FN_LSB];
			f_ext = 4'h0;
		end else begin
			f_bus = addr[`CTC_X_BUS_MSB:`CTC_X_BUS_LSB];
			f_dev = addr[`CTC_X_DEV_MSB:`CTC_X_DEV_LSB];
			f_fn  = addr[`CTC_X_FN_MSB:`CTC_X_FN_LSB];
			f_ext = addr[`CTC_X_EXT_MSB:`CTC_X_EXT_LSB];
		end
		kind = classify(f_bus, sec_bus, sub_bus);
	end

	// Parallel side claims only well formed config cycles
	assign fmt_ok = (addr[1:0] == `CTC_AD_TYPE1) &&
		((cmd == `CTC_CMD_CFG_RD) || (cmd == `CTC_CMD_CFG_WR)); // [RULE12]

	// Reject reasons; first match decides the answer
	always_comb begin
		accept      = 1'b0;
		rej_sts     = CTC_STS_SC;
		rej_ma      = 1'b0;
		rej_invalid = 1'b0;
		if (reverse) begin
			if (!fmt_ok) begin
				rej_sts = CTC_STS_NOCLAIM; // [RULE12]
			end else if (kind == CTC_K_BAD) begin
				rej_sts     = CTC_STS_NOCLAIM; // [RULE5]
				rej_invalid = 1'b1;
			end else if ((kind == CTC_K_T0) && (f_dev != 5'h0)) begin
				rej_sts = CTC_STS_NOCLAIM; // [RULE13]
			end else begin
				accept = 1'b1;
			end
		end else begin
			if (kind == CTC_K_BAD) begin
				rej_sts = CTC_STS_UR; // [RULE4]
			end else if (f_ext != 4'h0) begin
				rej_sts = CTC_STS_UR; // [RULE10]
				rej_ma  = 1'b1;
			end else if ((kind == CTC_K_T0) && f_dev[4]) begin
				// Only sixteen select lines exist above bit 15
				rej_sts = CTC_STS_UR;
				rej_ma  = 1'b1;
			end else begin
				accept = 1'b1;
			end
		end
	end

endmodule : ctc_route
`default_nettype wire

/* verilog/ctc_addr_build.sv */
// Builds the secondary side configuration address
`timescale 1ns/1ps
`default_nettype none
`include "ctc_defines.svh"

module ctc_addr_build
	import ctc_pkg::*;
(
	input  wire logic        reverse,
	input  wire ctc_kind_t   kind,
	input  wire logic [7:0]  f_bus,
	input  wire logic [4:0]  f_dev,
	input  wire logic [2:0]  f_fn,
	input  wire logic [5:0]  f_reg,
	output logic [31:0]      out_addr
);

	logic [15:0] idsel;

	// One select line per device number 0 to 15; the top device bit is ignored
	always_comb begin
		idsel = 16'h0000;
		idsel[f_dev[3:0]] = 1'b1; // [RULE9]
	end

	// Layout depends on direction and target type
	always_comb begin
		if (!reverse && (kind == CTC_K_T0)) begin
			out_addr = {idsel, 5'h00, f_fn, f_reg, `CTC_AD_TYPE0}; // [RULE8]
		end else if (!reverse) begin
			out_addr = {8'h00, f_bus, f_dev, f_fn, f_reg,
				`CTC_AD_TYPE1}; // [RULE16]
		end else if (kind == CTC_K_T0) begin
			out_addr = {f_bus, 5'h00, f_fn, 8'h00, f_reg,
				2'h0}; // [RULE14]
		end else begin
			out_addr = {f_bus, f_dev, f_fn, 8'h00, f_reg,
				2'h0}; // [RULE15]
		end
	end

endmodule : ctc_addr_build
`default_nettype wire

/* verilog/ctc_bridge.sv */
// Type 1 configuration decode, conversion and forwarding engine
//
// Functional notes
// [RULE1] Never produce special cycles from Type 1
// [RULE2] Bus equals secondary: send as Type 0
// [RULE3] Bus inside range above secondary: send Type 1
// [RULE4] Out of range invalid; Express primary answers UR
// [RULE5] Parallel primary leaves invalid request unclaimed
// [RULE6] Later requests get abort or all-ones data
// [RULE7] Type 0 only downstream, only on secondary
// [RULE8] Forward Type 0 low address field layout
// [RULE9] Forward Type 0 device as single select bit
// [RULE10] Nonzero extended address: UR plus master abort
// [RULE11] Every forwarded request waits for its completion
// [RULE12] Reverse claim needs 01b and config command
// [RULE13] Reverse Type 0 needs device number zero
// [RULE14] Reverse Type 0 Express header field layout
// [RULE15] Reverse Type 1 copies fields, clears extended
// [RULE16] Forward Type 1: 01b low, zero top byte
// [RULE17] Secondary completion returns to primary requester
`timescale 1ns/1ps
`default_nettype none
`include "ctc_defines.svh"

module ctc_bridge
	import ctc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        ce,
	input  wire logic        reverse_mode,
	input  wire logic [7:0]  sec_bus_num,
	input  wire logic [7:0]  sub_bus_num,
	input  wire logic        abort_reply_sel,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic        req_write,
	input  wire logic [3:0]  req_cmd,
	input  wire logic [31:0] req_addr,
	input  wire logic [31:0] req_wdata,
	input  wire logic [3:0]  req_be,
	output logic             rsp_valid,
	output ctc_sts_t         rsp_status,
	output logic [31:0]      rsp_rdata,
	output logic             sec_valid,
	input  wire logic        sec_ready,
	output logic             sec_type1,
	output logic             sec_write,
	output logic [31:0]      sec_addr,
	output logic [31:0]      sec_wdata,
	output logic [3:0]       sec_be,
	input  wire logic        cpl_valid,
	input  wire ctc_sts_t    cpl_status,
	input  wire logic [31:0] cpl_rdata,
	output logic             ma_rcvd
);

	// Decode results for the request on the primary port
	ctc_kind_t   kind;
	logic [7:0]  f_bus;
	logic [4:0]  f_dev;
	logic [2:0]  f_fn;
	logic [5:0]  f_reg;
	logic        accept;
	ctc_sts_t    rej_sts;
	logic        rej_ma;
	logic        rej_invalid;
	logic [31:0] built_addr;

	// Sequencer and registered outputs
	ctc_state_t  st_r;
	ctc_state_t  st_nxt;
	logic        req_ready_r;
	logic        rsp_valid_r;
	logic        rsp_nxt;
	ctc_sts_t    rsp_status_r;
	logic [31:0] rsp_rdata_r;
	logic        sec_valid_r;
	logic        sec_type1_r;
	logic        sec_write_r;
	logic [31:0] sec_addr_r;
	logic [31:0] sec_wdata_r;
	logic [3:0]  sec_be_r;
	logic        ma_rcvd_r;
	logic        abort_pend_r;
	logic        abort_pend_nxt;

	// Handshake terms
	logic        take;
	logic        use_pend;
	logic        issue_done;
	logic        cpl_take;

	// Decoder sees the live request; its result is used only at take
	ctc_route u_route (
		.reverse     (reverse_mode),
		.cmd         (req_cmd),
		.addr        (req_addr),
		.sec_bus     (sec_bus_num),
		.sub_bus     (sub_bus_num),
		.kind        (kind),
		.f_bus       (f_bus),
		.f_dev       (f_dev),
		.f_fn        (f_fn),
		.f_reg       (f_reg),
		.accept      (accept),
		.rej_sts     (rej_sts),
		.rej_ma      (rej_ma),
		.rej_invalid (rej_invalid)
	);

	// Address for the secondary side
	ctc_addr_build u_addr (
		.reverse  (reverse_mode),
		.kind     (kind),
		.f_bus    (f_bus),
		.f_dev    (f_dev),
		.f_fn     (f_fn),
		.f_reg    (f_reg),
		.out_addr (built_addr)
	);

	// A request is taken only while ready is shown
	assign take       = ce && req_valid && req_ready_r;
	// A pending abort answer consumes the next request itself
	assign use_pend   = take && abort_pend_r;
	assign issue_done = sec_valid_r && sec_ready;
	assign cpl_take   = (st_r == CTC_ST_WAIT) && cpl_valid;

	// Next state; rejected or pre-answered requests never leave idle
	always_comb begin
		st_nxt  = st_r;
		rsp_nxt = 1'b0;
		unique case (st_r)
			CTC_ST_IDLE: begin
				if (take && !use_pend && accept) begin
					st_nxt = CTC_ST_ISSUE;
				end else if (take) begin
					rsp_nxt = 1'b1;
				end
			end
			CTC_ST_ISSUE: begin
				if (issue_done) begin
					st_nxt = CTC_ST_WAIT; // [RULE11]
				end
			end
			CTC_ST_WAIT: begin
				if (cpl_valid) begin
					st_nxt  = CTC_ST_IDLE; // [RULE11]
					rsp_nxt = 1'b1;
				end
			end
			default: begin
				st_nxt = CTC_ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			st_r <= CTC_ST_IDLE;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// Ready returns one cycle after the answer pulse
	always_ff @(posedge clk) begin
		if (reset) begin
			req_ready_r <= 1'b0;
		end else if (ce) begin
			req_ready_r <= (st_nxt == CTC_ST_IDLE) && !rsp_nxt && !take;
		end
	end

	// Invalid parallel side request arms the abort answer
	always_comb begin
		abort_pend_nxt = abort_pend_r;
		if (use_pend) begin
			abort_pend_nxt = 1'b0;
		end
		// Consuming wins over arming
		if (take && !use_pend && reverse_mode && rej_invalid) begin
			abort_pend_nxt = 1'b1; // [RULE6]
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			abort_pend_r <= 1'b0;
		end else if (ce) begin
			abort_pend_r <= abort_pend_nxt;
		end
	end

	// Answer pulse to the primary requester
	always_ff @(posedge clk) begin
		if (reset) begin
			rsp_valid_r <= 1'b0;
		end else if (ce) begin
			rsp_valid_r <= rsp_nxt;
		end
	end

	// Answer status and data
	always_ff @(posedge clk) begin
		if (reset) begin
			rsp_status_r <= CTC_STS_SC;
			rsp_rdata_r  <= `CTC_RST_WORD;
		end else if (ce) begin
			if (use_pend) begin
				if (abort_reply_sel) begin
					rsp_status_r <= CTC_STS_TA; // [RULE6]
					rsp_rdata_r  <= `CTC_RST_WORD;
				end else begin
					rsp_status_r <= CTC_STS_SC; // [RULE6]
					rsp_rdata_r  <= `CTC_ALL_ONES;
				end
			end else if (take && !accept) begin
				// Unclaimed reads float high on the parallel side
				rsp_status_r <= rej_sts; // [RULE4] [RULE5]
				rsp_rdata_r  <= `CTC_ALL_ONES;
			end else if (cpl_take) begin
				rsp_status_r <= cpl_status; // [RULE17]
				rsp_rdata_r  <= cpl_rdata; // [RULE17]
			end
		end
	end

	// Master abort seen on the parallel bus for a blocked request
	always_ff @(posedge clk) begin
		if (reset) begin
			ma_rcvd_r <= 1'b0;
		end else if (ce) begin
			ma_rcvd_r <= take && !use_pend && !reverse_mode &&
				rej_ma; // [RULE10]
		end
	end

	// Secondary request valid holds until the far side accepts
	always_ff @(posedge clk) begin
		if (reset) begin
			sec_valid_r <= 1'b0;
		end else if (ce) begin
			if (take && !use_pend && accept) begin
				sec_valid_r <= 1'b1; // [RULE7]
			end else if (issue_done) begin
				sec_valid_r <= 1'b0;
			end
		end
	end

	// Secondary request contents, latched once at take
	always_ff @(posedge clk) begin
		if (reset) begin
			sec_type1_r <= 1'b0;
			sec_write_r <= 1'b0;
			sec_addr_r  <= `CTC_RST_WORD;
			sec_wdata_r <= `CTC_RST_WORD;
			sec_be_r    <= 4'h0;
		end else if (ce && take && !use_pend && accept) begin
			// Type 0 only for the bus right below us
			sec_type1_r <= (kind == CTC_K_T1); // [RULE2] [RULE3] [RULE7]
			// Only config read or write leaves here, never special
			sec_write_r <= req_write; // [RULE1]
			sec_addr_r  <= built_addr;
			sec_wdata_r <= req_wdata;
			sec_be_r    <= req_be;
		end
	end

	// Outputs come straight from flops
	assign req_ready  = req_ready_r;
	assign rsp_valid  = rsp_valid_r;
	assign rsp_status = rsp_status_r;
	assign rsp_rdata  = rsp_rdata_r;
	assign sec_valid  = sec_valid_r;
	assign sec_type1  = sec_type1_r;
	assign sec_write  = sec_write_r;
	assign sec_addr   = sec_addr_r;
	assign sec_wdata  = sec_wdata_r;
	assign sec_be     = sec_be_r;
	assign ma_rcvd    = ma_rcvd_r;

endmodule : ctc_bridge
`default_nettype wire

/* tb/ctc_bridge_checker.sv */
// Assertion checker for the Type 1 configuration bridge
`timescale 1ns/1ps
`default_nettype none

module ctc_bridge_checker
	import ctc_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        ce,
	input wire logic        reverse_mode,
	input wire logic [7:0]  sec_bus_num,
	input wire logic [7:0]  sub_bus_num,
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic [3:0]  req_cmd,
	input wire logic [31:0] req_addr,
	input wire logic        rsp_valid,
	input wire ctc_sts_t    rsp_status,
	input wire logic        sec_valid,
	input wire logic        sec_ready,
	input wire logic        sec_type1,
	input wire logic [31:0] sec_addr,
	input wire logic        ma_rcvd
);
	default clocking dcb @(posedge clk); endclocking
	default disable iff (reset);

	// Request taken and its forward bus field
	logic       take;
	logic [7:0] fbus;
	assign take = req_valid && req_ready && ce;
	assign fbus = req_addr[31:24];

	t0_low_a: assert property (
		sec_valid && !sec_type1 && !reverse_mode
		|-> sec_addr[1:0] == 2'h0 && sec_addr[15:11] == 5'h0)
		else $error("Type 0 low address bits wrong");
	t0_select_a: assert property (
		sec_valid && !sec_type1 && !reverse_mode |-> $onehot(sec_addr[31:16]))
		else $error("Type 0 select bits not one hot");
	fwd_t1_a: assert property (
		sec_valid && sec_type1 && !reverse_mode
		|-> sec_addr[1:0] == 2'h1 && sec_addr[31:24] == 8'h00
		&& sec_addr[23:16] > sec_bus_num && sec_addr[23:16] <= sub_bus_num)
		else $error("Forward Type 1 address wrong");
	rev_t0_a: assert property (
		sec_valid && !sec_type1 && reverse_mode
		|-> sec_addr[23:19] == 5'h0 && sec_addr[11:8] == 4'h0
		&& sec_addr[31:24] == sec_bus_num)
		else $error("Reverse Type 0 header wrong");
	rev_t1_a: assert property (
		sec_valid && sec_type1 && reverse_mode
		|-> sec_addr[11:8] == 4'h0 && sec_addr[31:24] > sec_bus_num
		&& sec_addr[31:24] <= sub_bus_num)
		else $error("Reverse Type 1 header wrong");
	rsp_pulse_a: assert property (
		rsp_valid |=> !rsp_valid)
		else $error("Answer longer than one cycle");
	ma_with_ur_a: assert property (
		ma_rcvd |-> rsp_valid && rsp_status == CTC_STS_UR)
		else $error("Master abort without UR answer");
	rev_claim_a: assert property (
		take && reverse_mode && (req_addr[1:0] != 2'h1
		|| req_cmd[3:1] != 3'h5) |=> rsp_valid && !sec_valid)
		else $error("Malformed reverse request claimed");
	fwd_bad_a: assert property (
		take && !reverse_mode && (fbus < sec_bus_num || fbus > sub_bus_num)
		|=> rsp_valid && !sec_valid && rsp_status != CTC_STS_NOCLAIM)
		else $error("Out of range forward request mishandled");
	// A completion may arrive in the first wait cycle, so only one is quiet
	np_wait_a: assert property (
		sec_valid && sec_ready |=> !rsp_valid)
		else $error("Answer before completion");
	ready_drop_a: assert property (
		take |=> !req_ready)
		else $error("Ready held after request taken");
	ready_back_a: assert property (
		rsp_valid && ce |=> req_ready)
		else $error("Ready not back after answer");

	// Main scenarios reached
	cover property (ma_rcvd);
	cover property (rsp_valid && rsp_status == CTC_STS_TA);
	cover property (sec_valid && sec_ready && sec_type1 && reverse_mode);
endmodule : ctc_bridge_checker

bind ctc_bridge ctc_bridge_checker u_chk (.*);

`default_nettype wire

/* tb/ctc_sec_model.sv */
// Behavioural model of the secondary side target
`timescale 1ns/1ps
`default_nettype none

module ctc_sec_model
	import ctc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        slow,
	input  wire ctc_sts_t    sts,
	input  wire logic        sec_valid,
	input  wire logic [31:0] sec_addr,
	output logic             sec_ready,
	output logic             cpl_valid,
	output ctc_sts_t         cpl_status,
	output logic [31:0]      cpl_rdata
);
	logic        busy_r;
	logic [2:0]  wait_r;
	logic [7:0]  cnt_r;
	logic [31:0] addr_r;

	// Lines wander outside a completion so stale data never matches
	assign cpl_rdata  = cpl_valid ? ~addr_r : {4{cnt_r}};
	assign cpl_status = cpl_valid ? sts : ctc_sts_t'(cnt_r[1:0]);

	// Accept, then complete once after a short or long wait
	always_ff @(posedge clk) begin
		cnt_r     <= cnt_r + 8'h01;
		cpl_valid <= 1'b0;
		if (reset) begin
			busy_r    <= 1'b0;
			sec_ready <= 1'b0;
			cnt_r     <= 8'h00;
		end else if (busy_r) begin
			wait_r <= wait_r - 3'h1;
			if (wait_r == 3'h0) begin
				cpl_valid <= 1'b1;
				busy_r    <= 1'b0;
			end
		end else if (sec_valid && sec_ready) begin
			busy_r    <= 1'b1;
			sec_ready <= 1'b0;
			addr_r    <= sec_addr;
			wait_r    <= slow ? 3'h5 : 3'h0;
		end else begin
			sec_ready <= sec_valid && (!slow || cnt_r[1:0] == 2'h0);
		end
	end
endmodule : ctc_sec_model

`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the Type 1 configuration bridge
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import ctc_pkg::*;
	logic        clk, reset, ce, reverse_mode, abort_reply_sel, slow;
	logic        req_valid, req_ready, req_write, rsp_valid, ma_rcvd;
	logic        sec_valid, sec_ready, sec_type1, sec_write, cpl_valid;
	logic        ab_r;
	logic [7:0]  sec_bus_num, sub_bus_num;
	logic [3:0]  req_cmd, req_be, sec_be, c;
	logic [31:0] req_addr, req_wdata, rsp_rdata, sec_addr, sec_wdata;
	logic [31:0] cpl_rdata, a, r;
	ctc_sts_t    rsp_status, cpl_status, sts;
	logic [69:0] sq[$];
	logic [35:0] rq[$];
	int          err_count, n_checks, cyc, k, seed;

	ctc_bridge dut (.*);
	ctc_sec_model u_sec (.*);

	task automatic chk(input string n, input logic [69:0] s, e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic test_done;
		chk("queues_empty", 66'(sq.size() + rq.size()), 66'h0);
		$display("Checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// Note the expected outcome, then hand one request over
	task automatic send;
		logic [7:0]  b;
		logic [4:0]  d;
		logic [2:0]  f;
		logic        eq, inr, ma;
		logic [31:0] sa;
		b   = reverse_mode ? a[23:16] : a[31:24];
		d   = reverse_mode ? a[15:11] : a[23:19];
		f   = reverse_mode ? a[10:8] : a[18:16];
		eq  = b == sec_bus_num;
		inr = b > sec_bus_num && b <= sub_bus_num;
		ma  = inr ? a[11:8] != 4'h0 : eq && (a[11:8] != 4'h0 || d[4]);
		if (reverse_mode)
			sa = {b, inr ? d : 5'h0, f, 8'h00, a[7:2], 2'h0};
		else if (inr)
			sa = {8'h00, b, d, f, a[7:2], 2'h1};
		else
			sa = {16'h1 << d[3:0], 5'h0, f, a[7:2], 2'h0};
		if (ab_r) begin
			ab_r = 1'b0;
			rq.push_back({2'b01, abort_reply_sel ? CTC_STS_TA : CTC_STS_SC,
				abort_reply_sel ? 32'h0000_0000 : 32'hFFFF_FFFF});
		end else if (reverse_mode && (a[1:0] != 2'h1 || c[3:1] != 3'h5
			|| !(inr || eq && d == 5'h0))) begin
			ab_r = a[1:0] == 2'h1 && c[3:1] == 3'h5 && !inr && !eq;
			rq.push_back({2'b01, CTC_STS_NOCLAIM, 32'hFFFF_FFFF});
		end else if (!reverse_mode && (ma || !inr && !eq)) begin
			rq.push_back({ma, 1'b0, CTC_STS_UR, 32'h0000_0000});
		end else begin
			sq.push_back({req_be, req_write, inr, req_wdata, sa});
			rq.push_back({2'b01, sts, ~sa});
		end
		req_addr  = a;
		req_cmd   = c;
		req_valid = 1'b1;
		do @(posedge clk); while (!req_ready);
		#1 req_valid = 1'b0;
		do @(posedge clk); while (!rsp_valid);
	endtask : send

	// Take the oldest note whenever a result shows
	always @(posedge clk) begin
		if (!reset && sec_valid && sec_ready) begin
			if (sq.size() == 0) chk("sec_extra", 66'h1, 66'h0);
			else chk("sec_req",
				{sec_be, sec_write, sec_type1, sec_wdata, sec_addr},
				sq.pop_front());
		end
		if (!reset && rsp_valid) begin
			if (rq.size() == 0) chk("rsp_extra", 66'h1, 66'h0);
			else begin
				chk("rsp_status", rsp_status, rq[0][33:32]);
				if (rq[0][34]) chk("rsp_data", rsp_rdata, rq[0][31:0]);
				chk("ma_rcvd", ma_rcvd, rq[0][35]);
				void'(rq.pop_front());
			end
		end
	end

	// Cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		{reset, ce, req_valid, ab_r} = 4'b1100;
		{reverse_mode, abort_reply_sel, slow, req_write} = 4'h0;
		{req_cmd, req_be, req_addr, req_wdata} = {4'h0, 4'hF, 64'h0};
		sts = CTC_STS_SC;
		sec_bus_num = 8'h10;
		sub_bus_num = 8'h13;
		seed = 23;
		repeat (12) @(posedge clk);
		#1 reset = 1'b0;
		for (k = 0; k < 400; k++) begin
			@(posedge clk);
			#1 r = $random(seed);
			a = $random(seed);
			req_wdata = $random(seed);
			reverse_mode = k[6];
			abort_reply_sel = r[31];
			slow = r[30];
			sts = ctc_sts_t'(r[29:28]);
			req_write = r[27];
			// Byte enables must reach the far side untouched
			req_be = r[19:16];
			c = r[8] ? r[12:9] : {3'h5, r[27]};
			if (reverse_mode) begin
				a[23:16] = 8'h0E + r[2:0];
				if (r[3]) a[15:11] = 5'h0;
				if (r[5] | r[6]) a[1:0] = 2'h1;
			end else begin
				a[31:24] = 8'h0E + r[2:0];
				if (r[3]) a[23:19] = 5'h0;
				if (!(r[4] & r[5])) a[11:8] = 4'h0;
			end
			send();
		end
		repeat (4) @(posedge clk);
		test_done();
	end
endmodule : testbench

`default_nettype wire
